// *** rtl/pwm_timer_pkg.sv ***
package pwm_timer_pkg;

    // Waveform mode select encodings
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PC_MAX = 3'h1;
    localparam logic [2:0] MODE_CTC = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_PC_CMPA = 3'h5;
    localparam logic [2:0] MODE_FAST_CMPA = 3'h7;
    localparam int MODE_HIGH_BIT = 2;

    // Compare output mode encodings
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV = 2'h3;

    // Counter extremes and reset values
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic OUT_RESET = 1'b0;

    // Prescale select codes: stopped, /1, /8, /64, /256, /1024
    localparam logic [2:0] PRE_STOP = 3'h0;
    localparam logic [2:0] PRE_DIV1 = 3'h1;
    localparam logic [2:0] PRE_DIV8 = 3'h2;
    localparam logic [2:0] PRE_DIV64 = 3'h3;
    localparam logic [2:0] PRE_DIV256 = 3'h4;
    localparam logic [2:0] PRE_DIV1024 = 3'h5;
    localparam int PRE_WIDTH = 10;
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    typedef struct packed {
        logic [2:0] waveform_mode_select;
        logic [2:0] prescale_select;
        logic [1:0] channel_a_output_mode;
        logic [1:0] channel_b_output_mode;
    } timer_cfg_t;

endpackage : pwm_timer_pkg

// *** rtl/tick_prescaler.sv ***
`timescale 1ns/1ps
module tick_prescaler (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [2:0] select_in,
    output logic tick_out
);
    logic [pwm_timer_pkg::PRE_WIDTH-1:0] div_q;
    logic [pwm_timer_pkg::PRE_WIDTH-1:0] mask;
    logic running;
    logic tick_d;

    // Only the five legal division factors produce ticks
    assign mask = (select_in == pwm_timer_pkg::PRE_DIV1) ?
                      pwm_timer_pkg::MASK_DIV1 :
                  (select_in == pwm_timer_pkg::PRE_DIV8) ?
                      pwm_timer_pkg::MASK_DIV8 :
                  (select_in == pwm_timer_pkg::PRE_DIV64) ?
                      pwm_timer_pkg::MASK_DIV64 :
                  (select_in == pwm_timer_pkg::PRE_DIV256) ?
                      pwm_timer_pkg::MASK_DIV256 :
                      pwm_timer_pkg::MASK_DIV1024;
    assign running = (select_in >= pwm_timer_pkg::PRE_DIV1) &&
                     (select_in <= pwm_timer_pkg::PRE_DIV1024);
    assign tick_d = running && ((div_q & mask) == mask);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= '0;
            tick_out <= 1'b0;
        end else begin
            div_q <= running ? div_q + 1'b1 : '0;
            tick_out <= tick_d;
        end
    end
endmodule : tick_prescaler

// *** rtl/pwm_timer.sv ***
// What this block does
// - Modes 3 and 7 run fast PWM, counting BOTTOM to TOP then restarting.
// - Fast PWM TOP is 0xFF in mode 3, channel A compare in mode 7.
// - Fast non-inverting: clear output on match, set it at BOTTOM.
// - Fast inverting: set output on match, clear it at BOTTOM.
// - Compare output mode 2 is non-inverted, 3 inverted, both channels.
// - Fast counter clears on the tick after TOP; output edge on that tick.
// - Fast PWM sets the overflow flag on the tick that wraps TOP to BOTTOM.
// - Fast PWM mode 1 toggles channel A only with the mode high bit.
// - Fast: compare BOTTOM gives one-tick spikes, MAX a constant level.
// - Fast PWM double buffers compare values, toggle use included.
// - Modes 1 and 5 run phase correct PWM, counting up then down.
// - Phase correct TOP is 0xFF in mode 1, channel A compare in mode 5.
// - Phase correct: clear on up match, set on down match; inverse too.
// - Phase correct counter reverses at TOP, holding TOP one tick.
// - Phase correct PWM sets the overflow flag at BOTTOM.
// - Phase correct mode 1 toggles channel A only with mode high bit.
// - Phase correct: compare BOTTOM holds low, MAX holds high; inverted.
// - Level held at MAX is replaced by up-match result at next period.
// - A missed up-count match still yields its transition at TOP.
// - Counter is synchronous; timer tick only enables updates.
// - Tick divides the clock by 1, 8, 64, 256 or 1024.
// - Output mode zero takes no action and leaves the pin to the port.
// - Reset clears each channel's internal output state bit.
// - A count write blocks compare matches in the next tick.
`timescale 1ns/1ps
module pwm_timer #(
    parameter int CHANNELS = 2
) (
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire pwm_timer_pkg::timer_cfg_t CFG_IN,
    input wire logic COUNT_WR_IN,
    input wire logic [7:0] COUNT_WDATA_IN,
    input wire logic [CHANNELS-1:0] CMP_WR_IN,
    input wire logic [7:0] CMP_WDATA_IN,
    input wire logic OVF_CLR_IN,
    input wire logic [CHANNELS-1:0] MATCH_CLR_IN,
    output logic [7:0] COUNT_OUT,
    output logic [CHANNELS-1:0] PWM_OUT,
    output logic [CHANNELS-1:0] PWM_DRIVE_OUT,
    output logic OVF_FLAG_OUT,
    output logic [CHANNELS-1:0] MATCH_FLAG_OUT
);
    logic timer_tick;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic up_q;
    logic up_d;
    logic block_q;
    logic ovf_q;
    logic [7:0] act_all [CHANNELS];
    logic [2:0] mode;
    logic is_fast;
    logic is_pc;
    logic is_ctc;
    logic is_pwm;
    logic mode_high;
    logic [7:0] top_val;
    logic at_top;
    logic at_bot;
    logic fast_wrap;
    logic pc_top;
    logic pc_bot;
    logic plain_wrap;
    logic buf_load;
    logic ovf_set;
    logic [7:0] count_inc;
    logic [7:0] count_dec;
    logic [7:0] pc_next;
    logic [7:0] run_next;

    tick_prescaler tick_prescaler_inst (
        .clk_in(REF_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .select_in(CFG_IN.prescale_select),
        .tick_out(timer_tick)
    );

    // Mode decode
    assign mode = CFG_IN.waveform_mode_select;
    assign is_fast = (mode == pwm_timer_pkg::MODE_FAST_MAX) ||
                     (mode == pwm_timer_pkg::MODE_FAST_CMPA);
    assign is_pc = (mode == pwm_timer_pkg::MODE_PC_MAX) ||
                   (mode == pwm_timer_pkg::MODE_PC_CMPA);
    assign is_ctc = (mode == pwm_timer_pkg::MODE_CTC);
    assign is_pwm = is_fast || is_pc;
    assign mode_high = mode[pwm_timer_pkg::MODE_HIGH_BIT];

    // TOP comes from channel A compare in the upper PWM modes and CTC
    assign top_val = (is_ctc || (is_pwm && mode_high)) ? act_all[0] :
                     pwm_timer_pkg::MAX;
    assign at_top = (count_q == top_val);
    assign at_bot = (count_q == pwm_timer_pkg::BOTTOM);

    // Tick-qualified counter events
    assign fast_wrap = timer_tick && is_fast && at_top;
    assign pc_top = timer_tick && is_pc && up_q && at_top;
    assign pc_bot = timer_tick && is_pc && !up_q && at_bot;
    assign plain_wrap = timer_tick && !is_pwm &&
                        (count_q == pwm_timer_pkg::MAX);

    // Buffers load once per period in PWM, at once otherwise
    assign buf_load = !is_pwm || fast_wrap || pc_top;

    assign ovf_set = fast_wrap || pc_bot || plain_wrap;

    // Next count
    assign count_inc = count_q + 8'h01;
    assign count_dec = count_q - 8'h01;
    assign pc_next = up_q ?
                     (at_top ? (at_bot ? count_q : count_dec) : count_inc) :
                     (at_bot ? count_inc : count_dec);
    assign run_next = is_pc ? pc_next :
                      ((is_fast || is_ctc) && at_top) ?
                          pwm_timer_pkg::BOTTOM : count_inc;
    assign count_d = COUNT_WR_IN ? COUNT_WDATA_IN :
                     timer_tick ? run_next : count_q;
    assign up_d = !is_pc ? 1'b1 :
                  !timer_tick ? up_q :
                  (up_q && at_top) ? 1'b0 :
                  (!up_q && at_bot) ? 1'b1 : up_q;

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            count_q <= pwm_timer_pkg::COUNT_RESET;
            up_q <= 1'b1;
        end else begin
            count_q <= count_d;
            up_q <= up_d;
        end
    end

    // Match blocking stands until the tick after a count write
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            block_q <= 1'b0;
        end else if (COUNT_WR_IN) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // Overflow flag: a set in the clear cycle wins
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (OVF_CLR_IN) begin
            ovf_q <= 1'b0;
        end
    end

    assign COUNT_OUT = count_q;
    assign OVF_FLAG_OUT = ovf_q;

    for (genvar g = 0; g < CHANNELS; g++) begin : gen_ch
        logic [7:0] buf_q;
        logic [7:0] act_q;
        logic oc_q;
        logic oc_d;
        logic flag_q;
        logic [1:0] com;
        logic toggle_ok;
        logic match;
        logic act_top;
        logic act_bot;
        logic up_lvl;
        logic down_lvl;
        logic pwm_pol;
        logic fast_oc;
        logic pc_oc;
        logic plain_oc;
        logic tog_oc;

        // Channel A owns the first mode field, the rest the second
        assign com = (g == 0) ? CFG_IN.channel_a_output_mode :
                                CFG_IN.channel_b_output_mode;
        assign toggle_ok = (g == 0) && mode_high;
        assign match = timer_tick && !block_q &&
                       (count_q == act_q);
        assign act_top = (act_q == top_val);
        assign act_bot = (act_q == pwm_timer_pkg::BOTTOM);
        assign pwm_pol = (com == pwm_timer_pkg::COM_NONINV) ||
                         (com == pwm_timer_pkg::COM_INV);
        assign up_lvl = (com == pwm_timer_pkg::COM_INV);
        assign down_lvl = (com == pwm_timer_pkg::COM_NONINV);
        assign tog_oc = match ? !oc_q : oc_q;

        // Fast PWM: match ignored when compare sits at TOP
        assign fast_oc = (match && !act_top) ?
                             (com == pwm_timer_pkg::COM_INV) :
                         fast_wrap ?
                             (com == pwm_timer_pkg::COM_NONINV) :
                             oc_q;

        // Phase correct: turn points restore symmetry
        assign pc_oc = pc_top ?
                           (act_top ? down_lvl : up_lvl) :
                       pc_bot ?
                           (act_bot ? up_lvl : down_lvl) :
                       (match && !act_top) ?
                           (up_q ? up_lvl : down_lvl) :
                           oc_q;

        // Normal and CTC: toggle, clear or set on match
        assign plain_oc = !match ? oc_q :
                          (com == pwm_timer_pkg::COM_TOGGLE) ? !oc_q :
                          (com == pwm_timer_pkg::COM_INV);

        assign oc_d = (com == pwm_timer_pkg::COM_OFF) ? oc_q :
                      !is_pwm ? plain_oc :
                      (com == pwm_timer_pkg::COM_TOGGLE) ?
                          (toggle_ok ? tog_oc : oc_q) :
                      !pwm_pol ? oc_q :
                      is_fast ? fast_oc : pc_oc;

        always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                buf_q <= pwm_timer_pkg::CMP_RESET;
                act_q <= pwm_timer_pkg::CMP_RESET;
                oc_q <= pwm_timer_pkg::OUT_RESET;
            end else begin
                if (CMP_WR_IN[g]) begin
                    buf_q <= CMP_WDATA_IN;
                end
                if (buf_load) begin
                    act_q <= buf_q;
                end
                oc_q <= oc_d;
            end
        end

        // Match flag: a set in the clear cycle wins
        always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                flag_q <= 1'b0;
            end else if (match) begin
                flag_q <= 1'b1;
            end else if (MATCH_CLR_IN[g]) begin
                flag_q <= 1'b0;
            end
        end

        assign act_all[g] = act_q;
        assign PWM_OUT[g] = oc_q;
        assign MATCH_FLAG_OUT[g] = flag_q;
        // Pin override: off for mode zero and unsupported toggle
        assign PWM_DRIVE_OUT[g] = (com != pwm_timer_pkg::COM_OFF) &&
            !(is_pwm && (com == pwm_timer_pkg::COM_TOGGLE) &&
              !toggle_ok);
    end
endmodule : pwm_timer

// *** bench/pwm_load_model.sv ***
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic [1:0] level_in,
    input wire logic [1:0] drive_in,
    output logic [1:0] pin_out
);
    // A pin left to the port rests at its pull-up level
    assign pin_out = (level_in & drive_in) | ~drive_in;
endmodule : pwm_load_model

// *** bench/pwm_timer_properties.sv ***
`timescale 1ns/1ps
module pwm_timer_properties #(
    parameter int CHANNELS = 2
) (
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire pwm_timer_pkg::timer_cfg_t CFG_IN,
    input wire logic COUNT_WR_IN,
    input wire logic [7:0] COUNT_WDATA_IN,
    input wire logic [7:0] COUNT_OUT,
    input wire logic [CHANNELS-1:0] PWM_OUT,
    input wire logic [CHANNELS-1:0] PWM_DRIVE_OUT,
    input wire logic OVF_FLAG_OUT
);
    logic [2:0] wm;
    logic [1:0] ca;
    logic [1:0] cb;
    logic hold;
    assign wm = CFG_IN.waveform_mode_select;
    assign ca = CFG_IN.channel_a_output_mode;
    assign cb = CFG_IN.channel_b_output_mode;
    assign hold = !COUNT_WR_IN;
    default clocking dc @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    sequence s_fast_wrap;
        wm == 3'h3 && hold && COUNT_OUT == 8'hFF ##1 COUNT_OUT == 8'h00;
    endsequence
    sequence s_pc_bottom;
        wm == 3'h1 && hold && COUNT_OUT == 8'h01 ##1
        wm == 3'h1 && hold && COUNT_OUT == 8'h00 ##1 COUNT_OUT == 8'h01;
    endsequence
    a_fast_top_wrap: assert property (
        wm == 3'h3 && hold && COUNT_OUT == 8'hFF |=>
        COUNT_OUT inside {8'hFF, 8'h00}) else $error("bad fast wrap");
    a_fast_up_step: assert property (
        wm == 3'h3 && hold && COUNT_OUT != 8'hFF |=>
        8'(COUNT_OUT - $past(COUNT_OUT)) inside {8'h00, 8'h01})
        else $error("bad fast step");
    a_fast_ovf_set: assert property (
        s_fast_wrap |-> OVF_FLAG_OUT) else $error("no fast overflow");
    a_fast_set_bottom: assert property (
        ca == 2'h2 ##0 s_fast_wrap |-> PWM_OUT[0]) else $error("no set");
    a_fast_clr_bottom: assert property (
        ca == 2'h3 ##0 s_fast_wrap |-> !PWM_OUT[0]) else $error("no clear");
    a_pc_top_turn: assert property (
        wm == 3'h1 && hold && COUNT_OUT == 8'hFF |=>
        COUNT_OUT inside {8'hFF, 8'hFE}) else $error("bad turn at top");
    a_pc_ovf_bottom: assert property (
        s_pc_bottom |-> OVF_FLAG_OUT) else $error("no bottom overflow");
    a_drive_chan_a: assert property (
        PWM_DRIVE_OUT[0] == (ca[1] || (ca == 2'h1 && (!wm[0] || wm[2]))))
        else $error("bad drive a");
    a_drive_chan_b: assert property (
        PWM_DRIVE_OUT[1] == (cb[1] || (cb == 2'h1 && !wm[0])))
        else $error("bad drive b");
    a_count_load: assert property (
        COUNT_WR_IN |=> COUNT_OUT == $past(COUNT_WDATA_IN))
        else $error("count write lost");
    a_reset_state: assert property (
        $rose(ARST_N_IN) |-> PWM_OUT == '0 && COUNT_OUT == 8'h00)
        else $error("bad reset state");
endmodule : pwm_timer_properties

bind pwm_timer pwm_timer_properties #(
    .CHANNELS(CHANNELS)
) pwm_timer_properties_inst (
    .REF_CLK_IN(REF_CLK_IN),
    .ARST_N_IN(ARST_N_IN),
    .CFG_IN(CFG_IN),
    .COUNT_WR_IN(COUNT_WR_IN),
    .COUNT_WDATA_IN(COUNT_WDATA_IN),
    .COUNT_OUT(COUNT_OUT),
    .PWM_OUT(PWM_OUT),
    .PWM_DRIVE_OUT(PWM_DRIVE_OUT),
    .OVF_FLAG_OUT(OVF_FLAG_OUT)
);

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pwm_timer_pkg::timer_cfg_t cfg = '0;
    logic cwr = 1'b0;
    logic [1:0] mwr = 2'h0;
    logic [7:0] wd = 8'h00;
    logic oclr = 1'b0;
    logic [1:0] mclr = 2'h0;
    logic [7:0] cnt;
    logic [1:0] pwm;
    logic [1:0] drv;
    logic [1:0] mfl;
    logic [1:0] pin;
    logic ovf;
    int miscompares = 0;
    int checked = 0;
    always #4 clk = ~clk;
    pwm_timer pwm_timer_inst (
        .REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CFG_IN(cfg),
        .COUNT_WR_IN(cwr), .COUNT_WDATA_IN(wd), .CMP_WR_IN(mwr),
        .CMP_WDATA_IN(wd), .OVF_CLR_IN(oclr), .MATCH_CLR_IN(mclr),
        .COUNT_OUT(cnt), .PWM_OUT(pwm), .PWM_DRIVE_OUT(drv),
        .OVF_FLAG_OUT(ovf), .MATCH_FLAG_OUT(mfl));
    pwm_load_model pwm_load_model_inst (
        .level_in(pwm), .drive_in(drv), .pin_out(pin));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic pulse(input logic c, input logic [1:0] m,
                         input logic [1:0] x, input logic [7:0] v);
        @(posedge clk);
        cwr <= c;
        mwr <= m;
        mclr <= x;
        wd <= v;
        @(posedge clk);
        cwr <= 1'b0;
        mwr <= 2'h0;
        mclr <= 2'h0;
    endtask : pulse
    task automatic setcfg(input logic [2:0] m, s, input logic [1:0] a, b);
        @(posedge clk);
        cfg <= '{m, s, a, b};
    endtask : setcfg
    // Level after a tick; a falling count means the down slope
    function automatic logic lvl(input logic [7:0] c, p, a,
                                 input logic inv, pc);
        return ((pc && c < p) ? c < a : c <= a) ^ inv;
    endfunction : lvl
    task automatic run(input logic [2:0] m, input logic [7:0] a,
                       input logic [1:0] ka, kb);
        logic [7:0] top, p, old, nb;
        logic [7:0] act[2];
        logic [7:0] pnd[2];
        logic [1:0] lp, k;
        logic tg, e, d;
        int seen;
        top = m[2] ? a : 8'hFF;
        act[0] = a;
        act[1] = 8'($urandom_range(int'(top)));
        nb = 8'($urandom_range(int'(top)));
        pnd = act;
        setcfg(m, pwm_timer_pkg::PRE_DIV1, ka, kb);
        pulse(1'b0, 2'h1, 2'h0, a);
        pulse(1'b0, 2'h2, 2'h0, act[1]);
        pulse(1'b1, 2'h0, 2'h0, top - 8'h01);
        seen = 0;
        p = cnt;
        for (int n = 0; n < 4200 && seen < 2; n++) begin
            @(negedge clk);
            if (cnt === top && p !== top) seen++;
            p = cnt;
        end
        chk(16'(seen), 16'h2);
        lp = pwm;
        for (int i = 0; i < 520; i++) begin
            @(posedge clk);
            oclr <= (i == 0);
            mwr <= (i == 20) ? 2'h2 : 2'h0;
            wd <= nb;
            @(negedge clk);
            // Buffer holds the new value only after the strobe's edge
            pnd[1] = (i == 22) ? nb : pnd[1];
            for (int ch = 0; ch < 2; ch++) begin
                old = act[ch];
                act[ch] = (p == top) ? pnd[ch] : act[ch];
                k = ch ? kb : ka;
                tg = k == 2'h1 && ch == 0 && m[2];
                d = k[1] | tg;
                e = k[1] ? lvl(cnt, p, act[ch], k[0], !m[1])
                         : lp[ch] ^ (tg && p == old);
                chk(16'(pwm[ch]), 16'(e));
                chk(16'(pwm[ch]), 16'(e));
                chk(16'({drv[ch], pin[ch]}), 16'({d, e | !d}));
            end
            chk(16'(cnt <= top), 16'h1);
            lp = pwm;
            p = cnt;
        end
        chk(16'(ovf), 16'h1);
    endtask : run
    initial begin
        static int md[10] = '{3, 3, 7, 1, 1, 5, 7, 1, 3, 5};
        static int ca[10] = '{0, 255, -1, 255, -1, 255, -1, 0, -1, -1};
        static int dv[5] = '{0, 8, 64, 256, 1024};
        logic [7:0] p, a;
        logic [2:0] m;
        int g, h, gap;
        void'($urandom(32'h6260A421));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({cnt, 2'h0, pwm, 1'b0, ovf, mfl}, 16'h0);
        setcfg(3'h0, 3'h0, 2'h0, 2'h0);
        pulse(1'b0, 2'h2, 2'h0, 8'h05);
        for (int v = 5; v >= 4; v--) begin
            pulse(1'b1, 2'h0, 2'h3, 8'(v));
            cfg.prescale_select <= pwm_timer_pkg::PRE_DIV1;
            repeat (6) @(posedge clk);
            cfg.prescale_select <= pwm_timer_pkg::PRE_STOP;
            @(negedge clk);
            chk(16'(mfl[1]), 16'(v == 4));
        end
        setcfg(3'h3, 3'h0, 2'h2, 2'h3);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            cfg.prescale_select <= k ? 3'(k + 1) : 3'h0;
            h = 0;
            g = 0;
            gap = 0;
            p = cnt;
            // First step may still come from the previous rate
            for (int n = 0; n < 3200 && h < 3; n++) begin
                @(negedge clk);
                if (cnt !== p) begin
                    h++;
                    gap = g + 1;
                    g = 0;
                end else begin
                    g++;
                end
                p = cnt;
            end
            chk(16'(gap), 16'(dv[k]));
        end
        for (int j = 0; j < 10; j++) begin
            m = 3'(md[j]);
            a = ca[j] < 0 ? 8'($urandom_range(255, m[2] ? 64 : 0))
                          : 8'(ca[j]);
            run(m, a, (j inside {2, 4, 5}) ? 2'h1 : 2'($urandom_range(3)),
                2'(j));
        end
        give_verdict();
    end
    initial begin
        #800000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
